// >>> rtl/dbg_serial_pkg.sv
package dbg_serial_pkg;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MODE = 8'h04;
    localparam logic [7:0] OFS_IRQ_EN = 8'h08;
    localparam logic [7:0] OFS_IRQ_DIS = 8'h0c;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_RX_HOLD = 8'h18;
    localparam logic [7:0] OFS_TX_HOLD = 8'h1c;
    localparam logic [7:0] OFS_BAUD = 8'h20;
    localparam int B_RX_CHAR_READY = 0;
    localparam int B_TX_HOLDING_FREE = 1;
    localparam int B_RXEND = 3;
    localparam int B_TXEND = 4;
    localparam int B_OVR = 5;
    localparam int B_FRM = 6;
    localparam int B_PAR = 7;
    localparam int B_TXIDLE = 9;
    localparam int B_TX_BUFFER_EMPTY_FLAG = 11;
    localparam int B_RX_BUFFER_FULL_FLAG = 12;
    localparam int B_DCCW = 30;
    localparam int B_DCCR = 31;
    localparam logic [31:0] IRQ_BITS = 32'hc0001afb;
    localparam int C_RSTRX = 2;
    localparam int C_RSTTX = 3;
    localparam int C_RXEN = 4;
    localparam int C_RXDIS = 5;
    localparam int C_TXEN = 6;
    localparam int C_TXDIS = 7;
    localparam int C_CLEAR_STATUS_CMD = 8;
    localparam int M_PAR_LO = 9;
    localparam int M_CHM_LO = 14;
    localparam logic [31:0] MODE_BITS = 32'h0000ce00;
    localparam logic [3:0] OVS = 4'hf;
    localparam logic [3:0] OVS_MID = 4'h7;
    typedef enum logic [1:0] {
        CH_NORMAL = 2'b00,
        CH_ECHO = 2'b01,
        CH_LOCAL = 2'b10,
        CH_REMOTE = 2'b11
    } channel_mode_sel_e;
endpackage

// >>> rtl/dbg_serial.sv
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// R1 - Channel mode: normal, echo, local, remote loopback.
// R2 - Enable register ones set mask bits.
// R3 - Disable register ones clear mask bits.
// R4 - Mask register reads enabled sources.
// R5 - All interrupt registers share one bit layout.
// R6 - Receive ready sets on load, clears on read.
// R7 - Transmit ready low while holding full or disabled.
// R8 - Overrun flag sticky until status clear.
// R9 - Framing flag sticky until status clear.
// R10 - Parity flag sticky until status clear.
// R11 - Transmitter empty only when holding and shifter idle.
// R12 - End bits mirror DMA end signals.
// R13 - Buffer bits mirror DMA buffer signals.
// R14 - Debug channel bits mirror pending signals.
// R15 - Receive holding returns character in low byte.
// R16 - Software queues next character in holding register.
// R17 - Divisor: zero off, one direct, else sixteen times.
// R18 - Status clear command clears three error flags.
// R19 - Echo sends receive pin to transmit pin.
// R20 - Local loopback feeds transmitter into receiver internally.
// R21 - Remote loopback wires receive pin to transmit.
// R22 - Interrupt is any status bit with mask set.
module dbg_serial (
    input wire logic I_CLK,
    input wire logic I_RESET,
    input wire logic [7:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [31:0] O_RDATA,
    input wire logic I_RX_PIN,
    output logic O_TX_PIN,
    input wire logic I_RX_XFER_END,
    input wire logic I_TX_XFER_END,
    input wire logic I_TX_BUF_EMPTY,
    input wire logic I_RX_BUF_FULL,
    input wire logic I_DCC_WRITE_PENDING,
    input wire logic I_DCC_READ_PENDING,
    output logic O_IRQ
);
    // Pin and neighbour inputs are asynchronous to I_CLK.
    logic [6:0] sync1_r, sync2_r;
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            sync1_r <= 7'h7f;
            sync2_r <= 7'h7f;
        end else begin
            sync1_r <= {I_RX_PIN, I_RX_XFER_END, I_TX_XFER_END,
                I_TX_BUF_EMPTY, I_RX_BUF_FULL, I_DCC_WRITE_PENDING,
                I_DCC_READ_PENDING};
            sync2_r <= sync1_r;
        end
    end
    wire rx_pin = sync2_r[6];

    logic [31:0] mask_r, mode_r;
    logic [15:0] baud_divisor_r;
    logic rx_en_r, tx_en_r;
    logic [7:0] rx_char_r, tx_char_r;
    logic rx_char_ready_r, tx_full_r;
    logic overrun_r, frame_r, parity_r;

    wire wr_ctrl = I_WR && I_ADDR == dbg_serial_pkg::OFS_CTRL;
    wire wr_mode = I_WR && I_ADDR == dbg_serial_pkg::OFS_MODE;
    wire wr_ien = I_WR && I_ADDR == dbg_serial_pkg::OFS_IRQ_EN;
    wire wr_idis = I_WR && I_ADDR == dbg_serial_pkg::OFS_IRQ_DIS;
    wire wr_thr = I_WR && I_ADDR == dbg_serial_pkg::OFS_TX_HOLD;
    wire wr_baud = I_WR && I_ADDR == dbg_serial_pkg::OFS_BAUD;
    wire rd_rhr = I_RD && I_ADDR == dbg_serial_pkg::OFS_RX_HOLD;
    wire clr_sta = wr_ctrl && I_WDATA[dbg_serial_pkg::C_CLEAR_STATUS_CMD];
    wire rst_rx = wr_ctrl && I_WDATA[dbg_serial_pkg::C_RSTRX];
    wire rst_tx = wr_ctrl && I_WDATA[dbg_serial_pkg::C_RSTTX];

    dbg_serial_pkg::channel_mode_sel_e channel_mode_sel;
    assign channel_mode_sel = dbg_serial_pkg::channel_mode_sel_e'(
        mode_r[dbg_serial_pkg::M_CHM_LO +: 2]); // R1
    wire [2:0] par_type = mode_r[dbg_serial_pkg::M_PAR_LO +: 3];
    wire remote = channel_mode_sel == dbg_serial_pkg::CH_REMOTE; // R21
    wire rx_on = rx_en_r && !remote;
    wire tx_on = tx_en_r && !remote;

    // Baud tick at sixteen times the bit rate; divisor 1 gives the
    // master clock itself as the oversample tick.
    logic [15:0] baud_cnt_r;
    logic tick_r;
    always_ff @(posedge I_CLK) begin
        if (I_RESET || baud_divisor_r == 16'h0000) begin // R17
            baud_cnt_r <= 16'h0000;
            tick_r <= 1'b0;
        end else if (baud_cnt_r >= baud_divisor_r - 16'h0001) begin
            baud_cnt_r <= 16'h0000;
            tick_r <= 1'b1; // R17
        end else begin
            baud_cnt_r <= baud_cnt_r + 16'h0001;
            tick_r <= 1'b0;
        end
    end

    // Transmitter: holding register feeds a shift register.
    logic tx_busy_r, tx_line_r;
    logic [3:0] tx_ovs_r, tx_bit_r;
    logic [10:0] tx_sh_r;
    wire has_par = !par_type[2];
    wire [3:0] nbits = has_par ? 4'ha : 4'h9;
    function automatic logic par_of(input logic [7:0] d,
                                    input logic [2:0] t);
        logic p;
        p = 1'b0;
        unique case (t[1:0])
            2'b00: p = ^d;
            2'b01: p = ~^d;
            2'b10: p = 1'b0;
            2'b11: p = 1'b1;
        endcase
        return p;
    endfunction
    // A character leaves the holding register only on a baud tick, so a
    // zero divisor keeps it waiting instead of driving a stuck start bit.
    wire tx_load = tx_on && tx_full_r && !tx_busy_r && tick_r; // R17
    wire tx_done = tx_busy_r && tick_r && tx_ovs_r == dbg_serial_pkg::OVS
        && tx_bit_r == nbits;
    always_ff @(posedge I_CLK) begin
        if (I_RESET || rst_tx) begin
            tx_busy_r <= 1'b0;
            tx_full_r <= 1'b0;
            tx_line_r <= 1'b1;
            tx_ovs_r <= 4'h0;
            tx_bit_r <= 4'h0;
            tx_sh_r <= 11'h7ff;
            tx_char_r <= 8'h00;
        end else begin
            if (wr_thr) begin // R16
                tx_char_r <= I_WDATA[7:0];
                tx_full_r <= 1'b1;
            end else if (tx_load) begin
                tx_full_r <= 1'b0;
            end
            if (tx_load) begin
                tx_busy_r <= 1'b1;
                tx_ovs_r <= 4'h0;
                tx_bit_r <= 4'h0;
                tx_sh_r <= has_par ? {1'b1, par_of(tx_char_r, par_type),
                    tx_char_r, 1'b0} : {2'b11, tx_char_r, 1'b0};
                tx_line_r <= 1'b0;
            end else if (tx_done) begin
                tx_busy_r <= 1'b0;
                tx_line_r <= 1'b1;
            end else if (tx_busy_r && tick_r) begin
                tx_ovs_r <= tx_ovs_r + 4'h1;
                if (tx_ovs_r == dbg_serial_pkg::OVS) begin
                    tx_bit_r <= tx_bit_r + 4'h1;
                    tx_sh_r <= {1'b1, tx_sh_r[10:1]};
                    tx_line_r <= tx_sh_r[1];
                end
            end
        end
    end

    // Receiver input chosen by channel mode.
    wire rx_in = channel_mode_sel == dbg_serial_pkg::CH_LOCAL ? tx_line_r
        : rx_pin; // R20
    logic rx_busy_r, rx_par_r;
    logic [3:0] rx_ovs_r, rx_bit_r;
    logic [7:0] rx_sh_r;
    wire rx_sample = rx_busy_r && tick_r && rx_ovs_r == dbg_serial_pkg::OVS_MID;
    wire rx_stop = rx_sample && rx_bit_r == nbits;
    wire rx_par_bad = has_par &&
        (rx_par_r != par_of(rx_sh_r, par_type));
    always_ff @(posedge I_CLK) begin
        if (I_RESET || rst_rx) begin
            rx_busy_r <= 1'b0;
            rx_ovs_r <= 4'h0;
            rx_bit_r <= 4'h0;
            rx_sh_r <= 8'h00;
            rx_par_r <= 1'b0;
        end else if (!rx_busy_r) begin
            if (rx_on && tick_r && !rx_in) begin
                rx_busy_r <= 1'b1;
                rx_ovs_r <= 4'h1;
                rx_bit_r <= 4'h0;
            end
        end else if (tick_r) begin
            rx_ovs_r <= rx_ovs_r + 4'h1;
            if (rx_sample) begin
                rx_bit_r <= rx_bit_r + 4'h1;
                if (rx_bit_r == 4'h0 && rx_in) begin
                    rx_busy_r <= 1'b0; // False start bit.
                end else if (rx_bit_r >= 4'h1 && rx_bit_r <= 4'h8) begin
                    rx_sh_r <= {rx_in, rx_sh_r[7:1]};
                end else if (rx_bit_r == 4'h9 && has_par) begin
                    rx_par_r <= rx_in;
                end
                if (rx_stop) begin
                    rx_busy_r <= 1'b0;
                end
            end
        end
    end

    // Holding register and sticky error flags; a set wins over a clear.
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            rx_char_r <= 8'h00;
            rx_char_ready_r <= 1'b0;
            overrun_r <= 1'b0;
            frame_r <= 1'b0;
            parity_r <= 1'b0;
        end else begin
            if (rx_stop) begin
                rx_char_r <= rx_sh_r;
                rx_char_ready_r <= 1'b1; // R6
            end else if (rd_rhr || rst_rx || !rx_en_r) begin
                rx_char_ready_r <= 1'b0; // R6
            end
            overrun_r <= (rx_stop && rx_char_ready_r && !rd_rhr)
                || (overrun_r && !clr_sta); // R8 R18
            frame_r <= (rx_stop && !rx_in)
                || (frame_r && !clr_sta); // R9 R18
            parity_r <= (rx_stop && rx_par_bad)
                || (parity_r && !clr_sta); // R10 R18
        end
    end

    // Software-visible configuration.
    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            mask_r <= 32'h00000000;
            mode_r <= 32'h00000000;
            baud_divisor_r <= 16'h0000;
            rx_en_r <= 1'b0;
            tx_en_r <= 1'b0;
        end else begin
            mask_r <= (mask_r | ({32{wr_ien}} & I_WDATA
                & dbg_serial_pkg::IRQ_BITS)) // R2 R5
                & ~({32{wr_idis}} & I_WDATA); // R3
            if (wr_mode) begin
                mode_r <= I_WDATA & dbg_serial_pkg::MODE_BITS;
            end
            if (wr_baud) begin
                baud_divisor_r <= I_WDATA[15:0];
            end
            if (wr_ctrl) begin
                if (I_WDATA[dbg_serial_pkg::C_RXDIS] || rst_rx) begin
                    rx_en_r <= 1'b0;
                end else if (I_WDATA[dbg_serial_pkg::C_RXEN]) begin
                    rx_en_r <= 1'b1;
                end
                if (I_WDATA[dbg_serial_pkg::C_TXDIS] || rst_tx) begin
                    tx_en_r <= 1'b0;
                end else if (I_WDATA[dbg_serial_pkg::C_TXEN]) begin
                    tx_en_r <= 1'b1;
                end
            end
        end
    end

    logic [31:0] status;
    always_comb begin
        status = 32'h00000000;
        status[dbg_serial_pkg::B_RX_CHAR_READY] = rx_char_ready_r;
        status[dbg_serial_pkg::B_TX_HOLDING_FREE] = tx_en_r && !tx_full_r; // R7
        status[dbg_serial_pkg::B_RXEND] = sync2_r[5]; // R12
        status[dbg_serial_pkg::B_TXEND] = sync2_r[4]; // R12
        status[dbg_serial_pkg::B_OVR] = overrun_r;
        status[dbg_serial_pkg::B_FRM] = frame_r;
        status[dbg_serial_pkg::B_PAR] = parity_r;
        status[dbg_serial_pkg::B_TXIDLE] =
            tx_en_r && !tx_full_r && !tx_busy_r; // R11
        status[dbg_serial_pkg::B_TX_BUFFER_EMPTY_FLAG] = sync2_r[3]; // R13
        status[dbg_serial_pkg::B_RX_BUFFER_FULL_FLAG] = sync2_r[2]; // R13
        status[dbg_serial_pkg::B_DCCW] = sync2_r[1]; // R14
        status[dbg_serial_pkg::B_DCCR] = sync2_r[0]; // R14
    end

    logic [31:0] rd_mux;
    always_comb begin
        unique case (I_ADDR)
            dbg_serial_pkg::OFS_MODE: rd_mux = mode_r;
            dbg_serial_pkg::OFS_IRQ_MASK: rd_mux = mask_r; // R4
            dbg_serial_pkg::OFS_STATUS: rd_mux = status;
            dbg_serial_pkg::OFS_RX_HOLD: rd_mux = {24'h000000, rx_char_r}; // R15
            dbg_serial_pkg::OFS_BAUD: rd_mux = {16'h0000, baud_divisor_r};
            default: rd_mux = 32'h00000000;
        endcase
    end

    logic tx_pin_nxt;
    always_comb begin
        unique case (channel_mode_sel)
            dbg_serial_pkg::CH_NORMAL: tx_pin_nxt = tx_line_r;
            dbg_serial_pkg::CH_ECHO: tx_pin_nxt = rx_pin; // R19
            dbg_serial_pkg::CH_LOCAL: tx_pin_nxt = 1'b1; // R20
            dbg_serial_pkg::CH_REMOTE: tx_pin_nxt = rx_pin; // R21
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET) begin
            O_RDATA <= 32'h00000000;
            O_TX_PIN <= 1'b1;
            O_IRQ <= 1'b0;
        end else begin
            O_RDATA <= I_RD ? rd_mux : 32'h00000000;
            O_TX_PIN <= tx_pin_nxt;
            O_IRQ <= |(status & mask_r); // R22
        end
    end

    a_mask_enable: assert property (@(posedge I_CLK) disable iff (I_RESET)
        wr_ien && !wr_idis |=> (mask_r & $past(I_WDATA)
        & dbg_serial_pkg::IRQ_BITS) == ($past(I_WDATA)
        & dbg_serial_pkg::IRQ_BITS)) else $error("enable lost"); // R2
    a_mask_disable: assert property (@(posedge I_CLK) disable iff (I_RESET)
        wr_idis |=> (mask_r & $past(I_WDATA)) == 32'h00000000)
        else $error("disable lost"); // R3
    a_irq_follow: assert property (@(posedge I_CLK) disable iff (I_RESET)
        ##1 O_IRQ == |($past(status) & $past(mask_r)))
        else $error("irq wrong"); // R22
    a_err_clear: assert property (@(posedge I_CLK) disable iff (I_RESET)
        clr_sta && !rx_stop |=> !overrun_r && !frame_r && !parity_r)
        else $error("status clear failed"); // R18
    a_ovr_sticky: assert property (@(posedge I_CLK) disable iff (I_RESET)
        overrun_r && !clr_sta |=> overrun_r)
        else $error("overrun lost"); // R8
    a_rx_char_ready_set: assert property (@(posedge I_CLK) disable iff (I_RESET)
        rx_stop |=> rx_char_ready_r && rx_char_r == $past(rx_sh_r))
        else $error("rx ready not set"); // R6
    a_tx_holding_free_dis: assert property (@(posedge I_CLK) disable iff (I_RESET)
        !tx_en_r |-> !status[dbg_serial_pkg::B_TX_HOLDING_FREE]
        && !status[dbg_serial_pkg::B_TXIDLE])
        else $error("tx flags with tx off"); // R11
    a_local_idle: assert property (@(posedge I_CLK) disable iff (I_RESET)
        channel_mode_sel == dbg_serial_pkg::CH_LOCAL [*2] |=> O_TX_PIN)
        else $error("local loop drives pin"); // R20
    a_baud_off: assert property (@(posedge I_CLK) disable iff (I_RESET)
        baud_divisor_r == 16'h0000 |=> !tick_r)
        else $error("baud runs at zero"); // R17
    a_tx_held_off: assert property (@(posedge I_CLK) disable iff (I_RESET)
        baud_divisor_r == 16'h0000 && !tick_r && !tx_busy_r |=> !tx_busy_r)
        else $error("tx starts with baud off"); // R17
endmodule
`default_nettype wire

// >>> verif/serial_term.sv
`timescale 1ns/10ps
`default_nettype none
// Terminal on the far side of the two serial pins; its line idles high.
module serial_term (
    input wire logic clk,
    input wire logic line_in,
    output var logic line_out
);
    initial line_out = 1'b1;
    task automatic drive(input logic v);
        @(posedge clk);
        line_out <= v;
    endtask
    task automatic hold(input logic v, input int n);
        drive(v);
        repeat (n - 1) @(posedge clk);
    endtask
    // Start bit, eight bits LSB first, optional parity bit, then the stop.
    task automatic send(input logic [7:0] c, input logic pe,
                        input logic pb, input logic sb, input int n);
        hold(1'b0, n);
        for (int i = 0; i < 8; i++) hold(c[i], n);
        if (pe) hold(pb, n);
        // A broken stop bit is cut short, so its low tail is not taken
        // by the receiver as the start of another character.
        if (sb) hold(sb, n);
        else hold(sb, n - n / 4);
        drive(1'b1);
    endtask
    // Returns in mid stop bit; an unknown result means no start bit came.
    task automatic get(output logic [7:0] c, input int n);
        int k;
        c = 'x;
        for (k = 0; k < 4000 && line_in !== 1'b0; k++) @(posedge clk);
        if (k == 4000) return;
        repeat (n / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (n) @(posedge clk);
            c[i] = line_in;
        end
        repeat (n) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk, rst, wr, rd, tx_pin, rx_pin, irq;
    logic [7:0] addr, c0, c1;
    logic [31:0] wdata, rdata, d;
    logic [5:0] mir;
    int bad_count = 0;
    int check_count = 0;
    int mb [6] = '{3, 4, 11, 12, 30, 31};
    logic [31:0] mt [3] = '{32'h4800, 32'hc800, 32'h0800};
    logic me [3] = '{1'b0, 1'b0, 1'b1};

    dbg_serial i_dbg_serial (
        .I_CLK(clk),
        .I_RESET(rst),
        .I_ADDR(addr),
        .I_WDATA(wdata),
        .I_WR(wr),
        .I_RD(rd),
        .O_RDATA(rdata),
        .I_RX_PIN(rx_pin),
        .O_TX_PIN(tx_pin),
        .I_RX_XFER_END(mir[0]),
        .I_TX_XFER_END(mir[1]),
        .I_TX_BUF_EMPTY(mir[2]),
        .I_RX_BUF_FULL(mir[3]),
        .I_DCC_WRITE_PENDING(mir[4]),
        .I_DCC_READ_PENDING(mir[5]),
        .O_IRQ(irq)
    );
    serial_term i_serial_term (
        .clk(clk),
        .line_in(tx_pin),
        .line_out(rx_pin)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic give_verdict();
        if (bad_count == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic st(input logic [31:0] m, input logic [31:0] e);
        rd_reg(dbg_serial_pkg::OFS_STATUS, d);
        chk(d & m, e);
    endtask
    task automatic pin(input logic e);
        chk({31'h0, tx_pin}, {31'h0, e});
    endtask
    task automatic wait_rx();
        for (int k = 0; k < 100; k++) begin
            rd_reg(dbg_serial_pkg::OFS_STATUS, d);
            if (d[0] === 1'b1) return;
        end
        bad_count++;
        give_verdict();
    endtask
    task automatic put(input logic [7:0] c, input logic pb, input logic sb);
        i_serial_term.send(c, 1'b1, pb, sb, 16);
        repeat (8) @(posedge clk);
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        bad_count++;
        give_verdict();
    end

    initial begin
        rst = 1'b1;
        {wr, rd, addr, wdata, mir} = '0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_reg(dbg_serial_pkg::OFS_IRQ_MASK, d);
        chk(d, 32'h0);
        st(32'hffffffff, 32'h0);
        rd_reg(dbg_serial_pkg::OFS_BAUD, d);
        chk(d, 32'h0);
        rd_reg(8'h24, d);
        chk(d, 32'h0);
        wr_reg(dbg_serial_pkg::OFS_IRQ_EN, 32'hffffffff);
        rd_reg(dbg_serial_pkg::OFS_IRQ_MASK, d);
        chk(d, 32'hc0001afb);
        wr_reg(dbg_serial_pkg::OFS_IRQ_DIS, 32'h81);
        wr_reg(dbg_serial_pkg::OFS_IRQ_EN, 32'h0);
        rd_reg(dbg_serial_pkg::OFS_IRQ_MASK, d);
        chk(d, 32'hc0001a7a);
        chk({31'h0, irq}, 32'h0);
        wr_reg(dbg_serial_pkg::OFS_IRQ_DIS, 32'hffffffff);
        rd_reg(dbg_serial_pkg::OFS_IRQ_MASK, d);
        chk(d, 32'h0);
        for (int i = 0; i < 6; i++) begin
            mir <= 6'h1 << i;
            wr_reg(dbg_serial_pkg::OFS_IRQ_EN, 32'h1 << mb[i]);
            repeat (4) @(posedge clk);
            #1 chk({31'h0, irq}, 32'h1);
            st(32'hffffffff, 32'h1 << mb[i]);
            wr_reg(dbg_serial_pkg::OFS_IRQ_DIS, 32'h1 << mb[i]);
            repeat (3) @(posedge clk);
            #1 chk({31'h0, irq}, 32'h0);
        end
        mir <= '0;
        wr_reg(dbg_serial_pkg::OFS_BAUD, 32'h5a5a0001);
        rd_reg(dbg_serial_pkg::OFS_BAUD, d);
        chk(d, 32'h1);
        wr_reg(dbg_serial_pkg::OFS_BAUD, 32'h0);
        wr_reg(dbg_serial_pkg::OFS_MODE, 32'h0800);
        wr_reg(dbg_serial_pkg::OFS_CTRL, 32'h40);
        st(32'hffffffff, 32'h202);
        wr_reg(dbg_serial_pkg::OFS_TX_HOLD, 32'hffffff3c);
        // With the divisor at zero the character must sit unsent.
        for (int i = 0; i < 40; i++) begin
            @(posedge clk);
            pin(1'b1);
        end
        st(32'h202, 32'h0);
        fork
            i_serial_term.get(c0, 32);
            begin
                wr_reg(dbg_serial_pkg::OFS_BAUD, 32'h2);
                repeat (40) @(posedge clk);
                wr_reg(dbg_serial_pkg::OFS_TX_HOLD, 32'hc3);
                st(32'h202, 32'h0);
            end
        join
        i_serial_term.get(c1, 32);
        chk({24'h0, c0}, 32'h3c);
        chk({24'h0, c1}, 32'hc3);
        repeat (40) @(posedge clk);
        st(32'h202, 32'h202);
        wr_reg(dbg_serial_pkg::OFS_BAUD, 32'h1);
        wr_reg(dbg_serial_pkg::OFS_MODE, 32'h0);
        wr_reg(dbg_serial_pkg::OFS_CTRL, 32'h10);
        put(8'ha5, 1'b0, 1'b1);
        wait_rx();
        rd_reg(dbg_serial_pkg::OFS_RX_HOLD, d);
        chk(d, 32'ha5);
        st(32'he1, 32'h0);
        put(8'h11, 1'b0, 1'b1);
        put(8'h22, 1'b0, 1'b1);
        st(32'he0, 32'h20);
        rd_reg(dbg_serial_pkg::OFS_RX_HOLD, d);
        put(8'h33, 1'b0, 1'b0);
        st(32'he0, 32'h60);
        rd_reg(dbg_serial_pkg::OFS_RX_HOLD, d);
        put(8'h44, 1'b1, 1'b1);
        st(32'he0, 32'he0);
        rd_reg(dbg_serial_pkg::OFS_RX_HOLD, d);
        st(32'he1, 32'he0);
        wr_reg(dbg_serial_pkg::OFS_CTRL, 32'h100);
        st(32'he0, 32'h0);
        put(8'h5a, 1'b0, 1'b1);
        wait_rx();
        wr_reg(dbg_serial_pkg::OFS_CTRL, 32'h20);
        st(32'h1, 32'h0);
        wr_reg(dbg_serial_pkg::OFS_CTRL, 32'h10);
        // Pulses stay shorter than half a bit so no frame is started.
        for (int m = 0; m < 3; m++) begin
            wr_reg(dbg_serial_pkg::OFS_MODE, mt[m]);
            i_serial_term.drive(1'b0);
            repeat (6) @(posedge clk);
            pin(me[m]);
            i_serial_term.drive(1'b1);
            repeat (6) @(posedge clk);
            pin(1'b1);
        end
        wr_reg(dbg_serial_pkg::OFS_MODE, 32'h8800);
        rd_reg(dbg_serial_pkg::OFS_RX_HOLD, d);
        i_serial_term.drive(1'b0);
        wr_reg(dbg_serial_pkg::OFS_TX_HOLD, 32'h5e);
        for (int i = 0; i < 100; i++) begin
            @(posedge clk);
            pin(1'b1);
        end
        wait_rx();
        rd_reg(dbg_serial_pkg::OFS_RX_HOLD, d);
        chk(d, 32'h5e);
        give_verdict();
    end
endmodule
`default_nettype wire
